// ==== core/otp_commit_pkg.sv ====
// package for the user otp commit control block: register map, field layout, commit states
// assumes a register-access front end (spi or i2c) delivers byte writes and reads at 8-bit addresses
package otp_commit_pkg;
	localparam logic [7:0] ADDR_COMMIT_CONTROL = 8'h11;
	localparam logic [7:0] COMMIT_CONTROL_RESET = 8'h00;
	localparam int BIT_TRIGGER = 7;
	localparam int BIT_QUAL_A = 3;
	localparam int BIT_QUAL_B = 2;
	localparam int REGION_LSB = 0;
	localparam logic [1:0] REGION_ZERO = 2'h0;
	localparam logic [1:0] REGION_ONE = 2'h1;
	localparam logic [1:0] REGION_TWO = 2'h2;
	localparam int BANK_WORDS = 16;
	localparam int REGION_TWO_WORDS = 16;
	// index of the lowpass selection inside region two, left out of its burn
	localparam logic [3:0] LOWPASS_INDEX = 4'h0;
	localparam logic [7:0] CHECK_SEED = 8'hff;
	// nonvolatile programming time per word, in ns; BURN_CYCLES holds it rounded up to cycles of core_clk
	localparam int BURN_NS = 100;
	localparam int CLK_NS = 4;
	localparam logic [15:0] BURN_CYCLES = 16'((BURN_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CHECK = 3'b001,
		ST_BURN = 3'b010,
		ST_LOCK = 3'b011
	} commit_state_e;

	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic active;
		logic [1:0] region;
		logic [3:0] index;
		logic [7:0] data;
	} burn_port_s;
endpackage : otp_commit_pkg

// ==== core/otp_check_code.sv ====
// running check code over a byte stream, one byte a cycle
// assumes the caller clears it before or with the first byte of each run
`timescale 1ns/1ps
module otp_check_code (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clear,
	input wire logic enable,
	input wire logic [7:0] dataIn,
	output logic [7:0] code
);
	import otp_commit_pkg::*;

	logic [7:0] code_r;
	logic [7:0] code_nxt;

	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ 8'h2f) : (r << 1);
		end
		return r;
	endfunction : crc8_step

	// a clear with enable starts a new run with its first byte, so no byte is lost at the seam
	assign code_nxt = clear ? (enable ? crc8_step(CHECK_SEED, dataIn) : CHECK_SEED)
		: (enable ? crc8_step(code_r, dataIn) : code_r);
	assign code = code_r;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			code_r <= CHECK_SEED;
		end else begin
			code_r <= code_nxt;
		end
	end
endmodule : otp_check_code

// ==== core/user_otp_commit_control.sv ====
// commit control: mirror bank writes, commit decode, check code, burn, lock and change watch
// assumes the serial front end hands over single-cycle register requests; init lock comes from the lock register
`timescale 1ns/1ps
module user_otp_commit_control (
	input wire logic core_clk,
	input wire logic srst,
	input otp_commit_pkg::reg_req_s regReq,
	input wire logic [1:0] bankRegion,
	input wire logic bankSelect,
	input wire logic [3:0] bankIndex,
	input wire logic initCompleteLock,
	output logic [7:0] readData,
	output logic [2:0] regionLocked,
	output logic [7:0] regionCheck0,
	output logic [7:0] regionCheck1,
	output logic [7:0] regionCheck2,
	output logic changeError,
	output logic commitBusy,
	output otp_commit_pkg::burn_port_s burnPort
);
	import otp_commit_pkg::*;

	logic [7:0] control_r;
	logic [7:0] sharedBank_r [BANK_WORDS];
	logic [7:0] regionTwo_r [REGION_TWO_WORDS];
	logic [1:0] bankBase_r;
	commit_state_e state_r;
	commit_state_e state_nxt;
	logic [1:0] target_r;
	logic [3:0] index_r;
	logic [15:0] wait_r;
	logic [2:0] locked_r;
	logic [7:0] check_r [3];
	logic [7:0] ctrlCheck_r;
	logic changeError_r;
	logic [7:0] readData_r;
	burn_port_s burn_r;
	logic [3:0] watchIdx_r;
	logic [7:0] watchCode_r;

	function automatic logic [2:0] decode_commit(input logic [7:0] w);
		// returns {valid, region}
		logic [1:0] reg2;
		reg2 = w[REGION_LSB +: 2];
		if (reg2 == REGION_ZERO || reg2 == REGION_ONE) begin
			return {1'b1, reg2};
		end else if (reg2 == REGION_TWO && w[BIT_QUAL_A] && w[BIT_QUAL_B]) begin
			return {1'b1, reg2};
		end
		return 3'b000;
	endfunction : decode_commit

	wire writesOpen = !initCompleteLock;
	wire controlWrite = regReq.write && regReq.addr == ADDR_COMMIT_CONTROL && writesOpen;
	wire [2:0] decoded = decode_commit(regReq.wdata);
	wire decodedValid = decoded[2];
	wire [1:0] decodedRegion = decoded[1:0];
	// a commit needs the trigger, a defined region, an idle engine and an unlocked target
	wire commitStart = controlWrite && regReq.wdata[BIT_TRIGGER] && decodedValid
		&& state_r == ST_IDLE && !locked_r[decodedRegion];
	wire bankWrite = regReq.write && bankSelect && writesOpen && state_r == ST_IDLE;
	wire lastWord = index_r == 4'hf;
	wire waitDone = wait_r == 16'h0;
	wire [7:0] burnWord = (target_r == REGION_TWO) ? regionTwo_r[index_r] : sharedBank_r[index_r];
	wire skipWord = target_r == REGION_TWO && index_r == LOWPASS_INDEX;
	wire [7:0] checkCode;
	wire checkRun = state_r == ST_CHECK && !skipWord;
	// pass restarts at word 0; the code then covers all sixteen words of the previous pass
	wire watchWrap = watchIdx_r == 4'h0;
	wire [7:0] watchWord = (bankBase_r == REGION_TWO) ? regionTwo_r[watchIdx_r] : sharedBank_r[watchIdx_r];
	wire [7:0] watchNext;

	otp_check_code u_check (
		.core_clk(core_clk),
		.srst(srst),
		.clear(commitStart),
		.enable(checkRun),
		.dataIn(burnWord),
		.code(checkCode)
	);

	otp_check_code u_watch (
		.core_clk(core_clk),
		.srst(srst),
		.clear(watchWrap),
		.enable(1'b1),
		.dataIn(watchWord),
		.code(watchNext)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (commitStart) begin
					state_nxt = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (lastWord) begin
					state_nxt = ST_BURN;
				end
			end
			ST_BURN: begin
				if (lastWord && waitDone) begin
					state_nxt = ST_LOCK;
				end
			end
			ST_LOCK: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= ST_IDLE;
			control_r <= COMMIT_CONTROL_RESET;
			target_r <= REGION_ZERO;
			index_r <= 4'h0;
			wait_r <= 16'h0;
		end else begin
			state_r <= state_nxt;
			if (controlWrite && state_r == ST_IDLE) begin
				control_r <= regReq.wdata;
			end
			if (commitStart) begin
				target_r <= decodedRegion;
				index_r <= 4'h0;
				wait_r <= BURN_CYCLES;
			end else if (state_r == ST_CHECK) begin
				index_r <= index_r + 4'h1;
			end else if (state_r == ST_BURN) begin
				if (waitDone || skipWord) begin
					index_r <= index_r + 4'h1;
					wait_r <= BURN_CYCLES;
				end else begin
					wait_r <= wait_r - 16'h1;
				end
			end
		end
	end

	// mirror bank: writes stage data only; a write outside region two moves the base
	always_ff @(posedge core_clk) begin
		if (srst) begin
			bankBase_r <= REGION_ZERO;
			// known contents keep the check codes and the change watch free of unknowns
			for (int i = 0; i < BANK_WORDS; i++) begin
				sharedBank_r[i] <= 8'h00;
			end
			for (int i = 0; i < REGION_TWO_WORDS; i++) begin
				regionTwo_r[i] <= 8'h00;
			end
		end else if (bankWrite) begin
			if (bankRegion == REGION_TWO) begin
				regionTwo_r[bankIndex] <= regReq.wdata;
			end else begin
				sharedBank_r[bankIndex] <= regReq.wdata;
				bankBase_r <= bankRegion;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			burn_r <= '0;
		end else begin
			burn_r.active <= state_r == ST_BURN && waitDone && !skipWord;
			burn_r.region <= target_r;
			burn_r.index <= index_r;
			burn_r.data <= burnWord;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			locked_r <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				check_r[i] <= 8'h00;
			end
		end else if (state_r == ST_LOCK) begin
			locked_r[target_r] <= 1'b1;
			check_r[target_r] <= checkCode;
		end
	end

	// change watch: recompute over the live bank; at each wrap, while idle, compare a locked region zero or one against its stored code
	always_ff @(posedge core_clk) begin
		if (srst) begin
			watchIdx_r <= 4'h0;
			watchCode_r <= 8'h00;
			ctrlCheck_r <= COMMIT_CONTROL_RESET;
			changeError_r <= 1'b0;
		end else begin
			watchIdx_r <= watchIdx_r + 4'h1;
			if (!initCompleteLock) begin
				ctrlCheck_r <= control_r;
			end
			if (watchWrap) begin
				watchCode_r <= watchNext;
				if (locked_r[bankBase_r] && state_r == ST_IDLE && bankBase_r != REGION_TWO
					&& watchNext != check_r[bankBase_r]) begin
					changeError_r <= 1'b1;
				end
			end
			if (initCompleteLock && ctrlCheck_r != control_r) begin
				changeError_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			readData_r <= 8'h00;
		end else if (regReq.read) begin
			if (regReq.addr == ADDR_COMMIT_CONTROL) begin
				readData_r <= control_r;
			end else if (bankSelect) begin
				readData_r <= (bankRegion == REGION_TWO) ? regionTwo_r[bankIndex] : sharedBank_r[bankIndex];
			end else begin
				readData_r <= 8'h00;
			end
		end
	end

	assign readData = readData_r;
	assign regionLocked = locked_r;
	assign regionCheck0 = check_r[0];
	assign regionCheck1 = check_r[1];
	assign regionCheck2 = check_r[2];
	assign changeError = changeError_r;
	assign commitBusy = state_r != ST_IDLE;
	assign burnPort = burn_r;
endmodule : user_otp_commit_control

// ==== tb/user_otp_commit_properties.sv ====
// checker: commit start, refusals, burn and lock relations of the commit control block
// assumes it is bound to user_otp_commit_control and sees only its ports
`timescale 1ns/1ps
module user_otp_commit_properties import otp_commit_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	input otp_commit_pkg::reg_req_s regReq,
	input wire logic initCompleteLock,
	input wire logic [2:0] regionLocked,
	input wire logic changeError,
	input wire logic commitBusy,
	input otp_commit_pkg::burn_port_s burnPort
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	wire ctlWr = regReq.write && regReq.addr == ADDR_COMMIT_CONTROL && !commitBusy;
	wire trig = ctlWr && regReq.wdata[BIT_TRIGGER] && !initCompleteLock;
	wire [1:0] sel = regReq.wdata[1:0];
	wire qual = regReq.wdata[BIT_QUAL_A] && regReq.wdata[BIT_QUAL_B];
	wire defined = sel != 2'h3 && (sel != REGION_TWO || qual);
	property p_start;
		trig && defined && !regionLocked[sel] |=> commitBusy;
	endproperty
	a_start: assert property (p_start) else $error("commit did not start");
	property p_reserved;
		trig && !defined |=> !commitBusy;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved commit started");
	property p_noTrigger;
		ctlWr && !regReq.wdata[BIT_TRIGGER] |=> !commitBusy;
	endproperty
	a_noTrigger: assert property (p_noTrigger) else $error("commit without trigger");
	property p_initLock;
		ctlWr && initCompleteLock |=> !commitBusy;
	endproperty
	a_initLock: assert property (p_initLock) else $error("commit under init lock");
	property p_locked;
		trig && defined && regionLocked[sel] |=> !commitBusy;
	endproperty
	a_locked: assert property (p_locked) else $error("locked region recommitted");
	property p_burnInBusy;
		burnPort.active |-> $past(commitBusy);
	endproperty
	a_burnInBusy: assert property (p_burnInBusy) else $error("burn outside commit");
	property p_lowpass;
		burnPort.active && burnPort.region == REGION_TWO |-> burnPort.index != LOWPASS_INDEX;
	endproperty
	a_lowpass: assert property (p_lowpass) else $error("lowpass word burned");
	property p_lockKeep;
		!$past(srst) |-> (regionLocked & $past(regionLocked)) == $past(regionLocked);
	endproperty
	a_lockKeep: assert property (p_lockKeep) else $error("lock flag cleared");
	property p_lockCause;
		!$past(srst) && regionLocked != $past(regionLocked) |-> $past(commitBusy);
	endproperty
	a_lockCause: assert property (p_lockCause) else $error("lock without commit");
	property p_busyEnds;
		$rose(commitBusy) |-> ##[1:1000] !commitBusy;
	endproperty
	a_busyEnds: assert property (p_busyEnds) else $error("commit never ends");
	property p_errSticky;
		!$past(srst) && $past(changeError) |-> changeError;
	endproperty
	a_errSticky: assert property (p_errSticky) else $error("change error dropped");
endmodule : user_otp_commit_properties
bind user_otp_commit_control user_otp_commit_properties props (.core_clk, .srst, .regReq, .initCompleteLock,
	.regionLocked, .changeError, .commitBusy, .burnPort);

// ==== tb/otp_host_model.sv ====
// host model: register requests, mirror staging and commit pacing
// assumes requests launch at the falling edge and are taken at the next rising edge
`timescale 1ns/1ps
module otp_host_model import otp_commit_pkg::*; (
	input wire logic core_clk,
	input wire logic commitBusy,
	input wire logic [7:0] readData,
	output otp_commit_pkg::reg_req_s regReq,
	output logic [1:0] bankRegion,
	output logic bankSelect,
	output logic [3:0] bankIndex
);
	initial begin
		regReq = '0;
		bankRegion = 2'h0;
		bankSelect = 1'b0;
		bankIndex = 4'h0;
	end
	task req(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s, input logic [1:0] r,
		input logic [3:0] i);
		@(negedge core_clk);
		regReq = '{write: w, read: !w, addr: a, wdata: d};
		bankSelect = s;
		bankRegion = r;
		bankIndex = i;
		@(negedge core_clk);
		// released address and data lines show inverted values, never a stale copy
		regReq = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
	endtask : req
	task rd(input logic [7:0] a, input logic s, input logic [1:0] r, input logic [3:0] i, output logic [7:0] d);
		req(1'b0, a, 8'h00, s, r, i);
		@(negedge core_clk);
		d = readData;
	endtask : rd
	task waitIdle(output bit ok);
		int n;
		for (n = 0; n < 2000 && commitBusy !== 1'b0; n++) @(negedge core_clk);
		ok = commitBusy === 1'b0;
	endtask : waitIdle
endmodule : otp_host_model

// ==== tb/user_otp_commit_control_tb.sv ====
// testbench: reserved codes, commits of all three regions, relock refusal, init lock
// assumes the checker is bound through its own file
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module user_otp_commit_control_tb;
	import otp_commit_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic initCompleteLock = 1'b0;
	reg_req_s regReq;
	logic [1:0] bankRegion;
	logic bankSelect;
	logic [3:0] bankIndex;
	logic [7:0] readData;
	logic [7:0] rdv;
	logic [2:0] regionLocked;
	logic changeError;
	logic commitBusy;
	burn_port_s burnPort;
	int err_count = 0;
	int compares = 0;
	int burns = 0;
	int cycles = 0;
	bit ok;
	user_otp_commit_control dut (.core_clk, .srst, .regReq, .bankRegion, .bankSelect, .bankIndex,
		.initCompleteLock, .readData, .regionLocked, .regionCheck0(), .regionCheck1(), .regionCheck2(),
		.changeError, .commitBusy, .burnPort);
	otp_host_model host (.core_clk, .commitBusy, .readData, .regReq, .bankRegion, .bankSelect, .bankIndex);
	initial forever #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (burnPort.active === 1'b1) burns++;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end
	task commit(input logic [7:0] v, input logic [2:0] locks, input int n);
		burns = 0;
		host.req(1'b1, ADDR_COMMIT_CONTROL, v, 1'b0, 2'h0, 4'h0);
		host.waitIdle(ok);
		repeat (2) @(negedge core_clk);
		`CHK("idle", 1'b1, ok)
		`CHK("locks", locks, regionLocked)
		`CHK("burns", n, burns)
		host.rd(ADDR_COMMIT_CONTROL, 1'b0, 2'h0, 4'h0, rdv);
		`CHK("control", v, rdv)
	endtask : commit
	task bank(input logic [1:0] r, input logic [3:0] i, input logic [7:0] d);
		host.req(1'b1, {4'ha, i}, d, 1'b1, r, i);
		host.rd({4'ha, i}, 1'b1, r, i, rdv);
		`CHK("bank word", d, rdv)
	endtask : bank
	task t_reserved;
		logic [7:0] codes[5] = '{8'h83, 8'h8b, 8'h82, 8'h86, 8'h8a};
		host.rd(ADDR_COMMIT_CONTROL, 1'b0, 2'h0, 4'h0, rdv);
		`CHK("control reset", COMMIT_CONTROL_RESET, rdv)
		foreach (codes[k]) commit(codes[k], 3'b000, 0);
		$display("done reserved");
	endtask : t_reserved
	task t_commits;
		`CHK("lock0 clear", 1'b0, regionLocked[0])
		bank(REGION_ZERO, 4'h1, 8'h5a);
		commit(8'h8c, 3'b001, BANK_WORDS);
		repeat (40) @(negedge core_clk);
		`CHK("no change", 1'b0, changeError)
		bank(REGION_ZERO, 4'h1, 8'ha5);
		repeat (40) @(negedge core_clk);
		`CHK("change seen", 1'b1, changeError)
		bank(REGION_ONE, 4'h2, 8'h77);
		commit(8'h81, 3'b011, BANK_WORDS);
		bank(REGION_TWO, 4'h3, 8'hc3);
		commit(8'h8e, 3'b111, REGION_TWO_WORDS - 1);
		commit(8'h8e, 3'b111, 0);
		bank(REGION_TWO, 4'h3, 8'h3c);
		$display("done commits");
	endtask : t_commits
	task t_initLock;
		@(negedge core_clk);
		initCompleteLock = 1'b1;
		host.req(1'b1, ADDR_COMMIT_CONTROL, 8'h01, 1'b0, 2'h0, 4'h0);
		host.rd(ADDR_COMMIT_CONTROL, 1'b0, 2'h0, 4'h0, rdv);
		`CHK("blocked write", 8'h8e, rdv)
		$display("done init lock");
	endtask : t_initLock
	task results;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	initial begin
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		srst = 1'b0;
		t_reserved();
		t_commits();
		t_initLock();
		results();
	end
endmodule : user_otp_commit_control_tb
